/* inj_capture_model.sv */
// capture input model: counts trigger rises
`default_nettype none
module inj_capture_model
(
  input wire logic clock_i,  // clock
  input wire logic rst_n_i,  // reset
  input wire logic trig_i,   // trigger in
  output var int   rises_o,  // rises seen
  output var int   period_o  // cycles between last two rises
);
  int   cyc_q;
  int   last_q;
  logic prev_q;
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      {rises_o, period_o, cyc_q, last_q, prev_q} <= '0;
    end
    else
    begin
      cyc_q <= cyc_q + 1;
      prev_q <= trig_i;
      // edge only: a held level is one request
      if (trig_i && !prev_q)
      begin
        rises_o <= rises_o + 1;
        period_o <= cyc_q - last_q;
        last_q <= cyc_q;
      end
    end
  end
endmodule : inj_capture_model
`default_nettype wire

/* inj_timer.sv */
// adc injection trigger timer with avalon-mm register slave
//
// Local design decision: the Avalon-MM interface to the registers.
`default_nettype none

// Overview of operation
// R1: timer works and is reachable only when both access enable bits set
// R2: enable low holds count; enable resets to zero
// R3: direction zero decrements before end value; resets to zero
// R4: direction one increments before end value
// R5: at end value with load and continue set, start value is loaded
// R6: at end value, no load, continue set: keep counting past end
// R7: at end value with continue clear the count freezes
// R8: at end value with output enable set, trigger output asserts
// R9: output enable clear keeps trigger output low
// R10: software keeps clock mode clear; counting clock comes from prescaler
// R11: prescaler divides peripheral clock by two to power two plus field
// R12: peripheral clock equals the module clock
// R13: count, start and end values are sixteen bits wide
// R14: period spans four cycles up to two to power thirty-three
// R15: software writes control first without enable, then sets enable
// R16: first counting edge after enable loads start value
// R17: trigger is a two-cycle pulse on rising edge of match
// R18: software changes settings only while stopped, toggling enable alone
// R19: prescaler counter is cleared while disabled
// R20: match compared every cycle, acted on at next counting edge
module inj_timer
  import inj_timer_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic        clock_i,                 // peripheral clock, 100 MHz
  input  wire logic        rst_n_i,                 // async reset, active low
  input  wire logic [15:0] avs_address_i,           // byte address
  input  wire logic        avs_read_i,              // read request
  input  wire logic        avs_write_i,             // write request
  input  wire logic [31:0] avs_writedata_i,         // write data
  input  wire logic [3:0]  avs_byteenable_i,        // byte lanes
  output logic      [31:0] avs_readdata_o,          // read data
  output logic             avs_waitrequest_o,       // stall
  output logic             injection_trigger_out_o  // to capture input channel
);

  // ******************************
  // reset release
  // ******************************
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ******************************
  // state types
  // ******************************
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,  // no request being answered
    BUS_ACK  = 1'b1   // waitrequest low this cycle
  } bus_state_t;

  typedef enum logic [1:0] {
    TMR_OFF = 2'b00,  // disabled, divider held clear
    TMR_ARM = 2'b01,  // enabled, waiting for the loading edge
    TMR_RUN = 2'b10   // counting between start and end
  } tmr_state_t;

  // ******************************
  // registers
  // ******************************
  logic [15:0]       timer_control_reg_q;
  logic [DATA_W-1:0] start_value_q;
  logic [DATA_W-1:0] end_value_q;
  logic [DATA_W-1:0] current_count_q;
  logic [1:0]        access_q;
  bus_state_t        bus_state_q;
  bus_state_t        bus_state_d;
  tmr_state_t        tmr_state_q;
  tmr_state_t        tmr_state_d;
  logic [PS_CNT_W-1:0] ps_cnt_q;
  logic              match_q;
  logic [1:0]        pulse_q;

  // merge byte lanes of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    logic [15:0] r;
    r = old_v;
    if (be[0]) r[7:0]  = wd[7:0];
    if (be[1]) r[15:8] = wd[15:8];
    return r;
  endfunction : merge16

  // low-bit mask of the divider: 2**(2+field) - 1
  function automatic logic [PS_CNT_W-1:0] ps_mask(input logic [3:0] field);
    logic [PS_CNT_W-1:0] m;
    m = (PS_CNT_W'(1) << (PS_BASE_EXP + int'(field))) - PS_CNT_W'(1);
    return m;
  endfunction : ps_mask

  logic periph_on;
  logic ack;
  logic bus_req;
  logic wr_take;
  logic rd_take;
  // R1: gated by both enables
  assign periph_on = access_q[EXT_PERIPH_ENABLE_BIT_POS] & access_q[PCFG_POS];
  assign ack       = (bus_state_q == BUS_ACK);
  assign bus_req   = (avs_read_i | avs_write_i) & ~ack;
  // writes land at the edge where the master sees waitrequest low
  assign wr_take   = avs_write_i & ack;
  // read data latched one edge early so it stands at the ack edge
  assign rd_take   = avs_read_i & ~ack;

  // ******************************
  // bus slave: one wait cycle, then ack
  // ******************************
  always_comb
  begin
    bus_state_d = bus_state_q;
    case (bus_state_q)
      BUS_IDLE:
        if (bus_req)
          bus_state_d = BUS_ACK;
      BUS_ACK:
        bus_state_d = BUS_IDLE;
      default:
        bus_state_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      bus_state_q <= BUS_IDLE;
    else
      bus_state_q <= bus_state_d;
  end

  always_ff @(posedge clock_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= ~bus_req;
  end

  logic [31:0] rdata_d;
  always_comb
  begin
    rdata_d = UNMAPPED_READ;
    if (avs_address_i == ACCESS_OFFSET)
      rdata_d = {30'h0000_0000, access_q};
    else if (!periph_on)
      rdata_d = UNMAPPED_READ;
    else if (avs_address_i == CTRL_OFFSET)
      rdata_d = {16'h0000, timer_control_reg_q};
    else if (avs_address_i == START_OFFSET)
      rdata_d = {16'h0000, start_value_q};
    else if (avs_address_i == END_OFFSET)
      rdata_d = {16'h0000, end_value_q};
    else if (avs_address_i == COUNT_OFFSET)
      rdata_d = {16'h0000, current_count_q};
    else
      rdata_d = UNMAPPED_READ;
  end

  always_ff @(posedge clock_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      avs_readdata_o <= UNMAPPED_READ;
    else if (rd_take)
      avs_readdata_o <= rdata_d;
  end

  always_ff @(posedge clock_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      access_q <= 2'h0;
    else if (wr_take && avs_address_i == ACCESS_OFFSET && avs_byteenable_i[0])
      access_q <= avs_writedata_i[1:0];
  end

  // R2: enable and other bits reset to zero
  always_ff @(posedge clock_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      timer_control_reg_q <= CTRL_RESET;
    else if (wr_take && periph_on && avs_address_i == CTRL_OFFSET)
      timer_control_reg_q <= merge16(timer_control_reg_q, avs_writedata_i,
                                     avs_byteenable_i) & CTRL_WMASK;
  end

  // R13: sixteen bit start and end values
  always_ff @(posedge clock_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      start_value_q <= VALUE_RESET;
      end_value_q   <= VALUE_RESET;
    end
    else if (wr_take && periph_on)
    begin
      if (avs_address_i == START_OFFSET)
        start_value_q <= merge16(start_value_q, avs_writedata_i, avs_byteenable_i);
      else if (avs_address_i == END_OFFSET)
        end_value_q <= merge16(end_value_q, avs_writedata_i, avs_byteenable_i);
    end
  end

  // ******************************
  // prescaler and counter
  // ******************************
  logic       enabled;
  logic [3:0] ps_field;
  logic       tick;
  assign enabled  = timer_control_reg_q[EN_POS] & periph_on;
  assign ps_field = timer_control_reg_q[PS_LSB +: 4];
  // R11: divide by 2**(2+field); tick when low bits all ones
  // R12: prescaler runs straight off the module clock
  // R10: clock mode bit ignored, internal clock always used
  assign tick = enabled && ((ps_cnt_q & ps_mask(ps_field)) == ps_mask(ps_field));

  // R19: clear divider while disabled
  always_ff @(posedge clock_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      ps_cnt_q <= '0;
    else if (!enabled)
      ps_cnt_q <= '0;
    else
      ps_cnt_q <= ps_cnt_q + PS_CNT_W'(1);
  end

  // divider is clear on entry to arm, so no tick can come from off
  always_comb
  begin
    tmr_state_d = tmr_state_q;
    case (tmr_state_q)
      TMR_OFF:
        if (enabled)
          tmr_state_d = TMR_ARM;
      TMR_ARM:
        if (!enabled)
          tmr_state_d = TMR_OFF;
        else if (tick)
          tmr_state_d = TMR_RUN;
      TMR_RUN:
        if (!enabled)
          tmr_state_d = TMR_OFF;
      default:
        tmr_state_d = TMR_OFF;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      tmr_state_q <= TMR_OFF;
    else
      tmr_state_q <= tmr_state_d;
  end

  logic running;
  assign running = (tmr_state_q == TMR_RUN);

  logic at_end;
  // R20: compare every cycle
  assign at_end = (current_count_q == end_value_q);

  logic [DATA_W-1:0] count_d;
  // R14: full span follows from 16-bit count and 4-bit prescaler
  always_comb
  begin
    count_d = current_count_q;
    // R2: hold while disabled
    if (!tick)
      count_d = current_count_q;
    // R16: first edge loads start value
    else if (!running)
      count_d = start_value_q;
    // R7: stop and freeze
    else if (at_end && !timer_control_reg_q[CONT_POS])
      count_d = current_count_q;
    // R5: reload start value
    else if (at_end && timer_control_reg_q[LOAD_POS])
      count_d = start_value_q;
    // R4: count up
    // R6: also past end
    else if (timer_control_reg_q[DIR_POS])
      count_d = current_count_q + DATA_W'(1);
    // R3: count down
    else
      count_d = current_count_q - DATA_W'(1);
  end

  always_ff @(posedge clock_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      current_count_q <= VALUE_RESET;
    else
      current_count_q <= count_d;
  end

  // ******************************
  // trigger output
  // ******************************
  always_ff @(posedge clock_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      match_q <= 1'b0;
    else
      match_q <= at_end & running;
  end

  // R17: two-cycle pulse on match rising edge
  always_ff @(posedge clock_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      pulse_q <= 2'h0;
    else if (at_end && running && !match_q)
      pulse_q <= 2'(PULSE_CYCLES);
    else if (pulse_q != 2'h0)
      pulse_q <= pulse_q - 2'h1;
  end

  // R8: assert on match when enabled; R9: low otherwise
  always_ff @(posedge clock_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      injection_trigger_out_o <= 1'b0;
    else
      injection_trigger_out_o <= timer_control_reg_q[OUTE_POS] & enabled &
                                 (pulse_q != 2'h0);
  end

endmodule : inj_timer
`default_nettype wire

/* inj_timer_pkg.sv */
// constants for the adc injection trigger timer
`default_nettype none
package inj_timer_pkg;
  // ******************************
  // register map (byte addresses)
  // ******************************
  localparam logic [15:0] CTRL_OFFSET   = 16'hC000;
  localparam logic [15:0] START_OFFSET  = 16'hC002;
  localparam logic [15:0] END_OFFSET    = 16'hC004;
  localparam logic [15:0] COUNT_OFFSET  = 16'hC006;
  localparam logic [15:0] ACCESS_OFFSET = 16'hC008;
  // ******************************
  // control field positions
  // ******************************
  localparam int EN_POS   = 0;
  localparam int DIR_POS  = 1;
  localparam int LOAD_POS = 2;
  localparam int CONT_POS = 3;
  localparam int OUTE_POS = 4;
  localparam int CM_POS   = 5;
  localparam int PS_LSB   = 6;
  localparam logic [15:0] CTRL_WMASK  = 16'h03FF;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  // access register: bit 0 ext periph enable, bit 1 periph config enable
  localparam int EXT_PERIPH_ENABLE_BIT_POS = 0;
  localparam int PCFG_POS = 1;
  // ******************************
  // timing
  // ******************************
  localparam int PS_BASE_EXP    = 2;
  localparam int PS_CNT_W       = 18;
  localparam int PULSE_CYCLES   = 2;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : inj_timer_pkg
`default_nettype wire

/* inj_timer_props.sv */
// port checker for the injection timer
`default_nettype none
module inj_timer_props
  import inj_timer_pkg::*;
(
  input wire logic        clock_i,                // clock
  input wire logic        rst_n_i,                // reset
  input wire logic        avs_read_i,             // read
  input wire logic        avs_write_i,            // write
  input wire logic [31:0] avs_readdata_o,         // read data
  input wire logic        avs_waitrequest_o,      // stall
  input wire logic        injection_trigger_out_o // trigger
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_pulse; injection_trigger_out_o ##1 !injection_trigger_out_o; endsequence
  property p_ack; $rose(avs_read_i | avs_write_i) |=> !avs_waitrequest_o; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_one: assert property (p_one) else $error("ack too long");
  property p_held; !avs_waitrequest_o |-> (avs_read_i | avs_write_i); endproperty
  a_held: assert property (p_held) else $error("ack without request");
  property p_idle; !(avs_read_i | avs_write_i) |-> avs_waitrequest_o; endproperty
  a_idle: assert property (p_idle) else $error("idle ack");
  property p_pulse; $rose(injection_trigger_out_o) |=> s_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length");
  property p_gap; $fell(injection_trigger_out_o) |-> !injection_trigger_out_o [*4]; endproperty
  a_gap: assert property (p_gap) else $error("pulse gap");
  property p_upper; !avs_waitrequest_o && avs_read_i |-> avs_readdata_o[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper half");
  property p_hold; !avs_read_i |=> $stable(avs_readdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule : inj_timer_props
bind inj_timer inj_timer_props u_props (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .injection_trigger_out_o(injection_trigger_out_o));
`default_nettype wire

/* test_adc_injection_trigger_timer.sv */
// testbench for the injection timer
`default_nettype none
module test_adc_injection_trigger_timer
  import inj_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i, rst_n_i, rd_q, wr_q, wait_o, trig_o;
  logic [15:0] addr_q;
  logic [31:0] wd_q, rdata, q;
  int          rises, period, n_mismatch, comparisons, s, l, base;
  inj_timer u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(addr_q),
    .avs_read_i(rd_q), .avs_write_i(wr_q), .avs_writedata_i(wd_q), .avs_byteenable_i(4'h3),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .injection_trigger_out_o(trig_o));
  inj_capture_model u_cap (.clock_i(clock_i), .rst_n_i(rst_n_i), .trig_i(trig_o),
    .rises_o(rises), .period_o(period));
  initial
  begin
    clock_i = 0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // waits on the stall; only the watchdog bounds a hang
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_q <= a;
    wd_q <= d;
    wr_q <= w;
    rd_q <= !w;
    do @(posedge clock_i); while (wait_o !== 1'b0);
    q = rdata;
    rd_q <= 0;
    wr_q <= 0;
  endtask : bus
  task automatic ck(input logic [15:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(q, e);
  endtask : ck
  task automatic run(input logic [15:0] c);
    logic [15:0] v;
    v = c;
    v[CM_POS] = 1'b0;
    bus(1, CTRL_OFFSET, {16'h0000, v});
    bus(1, CTRL_OFFSET, {16'h0000, v | 16'h0001});
  endtask : run
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    {rst_n_i, rd_q, wr_q, addr_q, wd_q, n_mismatch, comparisons} = '0;
    void'($urandom(13));
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1;
    repeat (3) @(posedge clock_i);
    bus(1, START_OFFSET, 32'h0000_0005);
    bus(1, ACCESS_OFFSET, 32'h0000_0003);
    ck(START_OFFSET, 0);
    ck(CTRL_OFFSET, 0);
    ck(END_OFFSET, 0);
    ck(COUNT_OFFSET, 0);
    ck(16'hC00A, 0);
    $display("access test done");
    for (int p = 0; p < 2; p++)
    begin
      s = $urandom_range(0, 60000);
      l = $urandom_range(1, 4);
      bus(1, START_OFFSET, s);
      bus(1, END_OFFSET, s + l);
      base = rises;
      run(16'h001E | 16'(p << 6));
      for (int n = 0; n < 400 && rises < base + 2; n++) @(posedge clock_i);
      chk(period, (l + 1) << (2 + p));
      bus(1, CTRL_OFFSET, 32'h001E | (p << 6));
    end
    $display("reload test done");
    s = $urandom_range(0, 60000);
    bus(1, START_OFFSET, s + 3);
    bus(1, END_OFFSET, s);
    base = rises;
    run(16'h0010);
    repeat (60) @(posedge clock_i);
    ck(COUNT_OFFSET, s);
    chk(rises - base, 1);
    bus(1, CTRL_OFFSET, 32'h0000_0010);
    $display("stop test done");
    bus(1, START_OFFSET, s);
    bus(1, END_OFFSET, s + 1);
    base = rises;
    run(16'h000A);
    repeat (60) @(posedge clock_i);
    bus(1, CTRL_OFFSET, 32'h0000_000A);
    bus(0, COUNT_OFFSET, 0);
    chk(q > s + 1, 1);
    chk(rises - base, 0);
    l = q;
    repeat (20) @(posedge clock_i);
    ck(COUNT_OFFSET, l);
    $display("continue test done");
    tally_and_finish();
  end
endmodule : test_adc_injection_trigger_timer
`default_nettype wire
